// file: rtl/cmp_unit.sv
// file: configurable magnitude comparator of counter against compare value
`timescale 1ns/1ps
`default_nettype none
module cmp_unit import timer_pkg::*; #(
    parameter int W = CNT_W
) (
    input wire logic [W-1:0] count,
    input wire logic [W-1:0] compare,
    input wire logic [2:0] rel,
    output logic match
);
    wire isLt = count < compare;
    wire isEq = count == compare;
    // unused relation codes never match, so a bad setting parks the output low
    assign match = (rel == REL_LT) ? isLt :
                   (rel == REL_LTE) ? (isLt | isEq) :
                   (rel == REL_EQ) ? isEq :
                   (rel == REL_GTE) ? !isLt :
                   (rel == REL_GT) ? (!isLt & !isEq) : 1'b0; // [R03]
endmodule
`default_nettype wire

// file: rtl/deadband_gen.sv
// file: complementary output pair with a programmable dead interval
`timescale 1ns/1ps
`default_nettype none
module deadband_gen import timer_pkg::*; #(
    parameter int W = DEAD_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pwmIn,
    input wire logic [W-1:0] deadLen,
    output logic hiOut,
    output logic loOut
);
    logic lvl_q;
    logic [W-1:0] cnt_q;
    logic hi_q;
    logic lo_q;
    wire change = pwmIn != lvl_q;
    wire settled = !change && (cnt_q == '0);
    // every edge costs at least one idle cycle, so the pair never overlaps
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lvl_q <= 1'b0;
            cnt_q <= '0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else begin
            lvl_q <= pwmIn;
            cnt_q <= change ? deadLen : (cnt_q == '0 ? cnt_q : cnt_q - W'(DEAD_STEP)); // [R12]
            hi_q <= settled & lvl_q; // [R12]
            lo_q <= settled & !lvl_q; // [R12]
        end
    end
    assign hiOut = hi_q;
    assign loOut = lo_q;
    property p_noOverlap;
        @(posedge mclk) disable iff (!rst_n) !(hi_q && lo_q);
    endproperty
    a_noOverlap: assert property (p_noOverlap) else $error("both pair outputs active"); // [R12]
    property p_gapOnEdge;
        @(posedge mclk) disable iff (!rst_n) change |=> !hi_q && !lo_q;
    endproperty
    a_gapOnEdge: assert property (p_gapOnEdge) else $error("no dead cycle on edge"); // [R12]
endmodule
`default_nettype wire

// file: rtl/timer_counter_pwm16.sv
// file: 16-bit down-counting timer, counter and pwm unit with register port
// What this block does
// R01: counter is a sixteen bit register that only counts down
// R02: counting clock picked by configuration from several sources
// R03: comparator relation selectable: lt, lte, eq, gte, gt
// R04: period loaded on start, on reset input and on terminal count
// R05: interrupt selectable from terminal count, compare true or capture
// R06: compare output, terminal count or complementary output, interrupt line
// R07: run modes free running, one shot, or gated by enable input
// R08: one shot stops after one period until started again
// R09: gated mode counts only while enable input is high
// R10: capture event latches the full count into a holding register
// R11: kill input forces comparator outputs inactive while it is high
// R12: complementary pwm pair with dead interval around each edge
// R13: terminal count output pulses once as count reloads from zero
// R14: live count readable without disturbing counting
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm16 import timer_pkg::*; #(
    parameter int NSRC = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic [NSRC-2:0] tickIn,
    input wire logic enableIn,
    input wire logic resetIn,
    input wire logic captureIn,
    input wire logic killIn,
    output logic cmpOut,
    output logic tcOut,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    logic runEn_q;
    logic [1:0] mode_q;
    logic [2:0] rel_q;
    logic [SEL_W-1:0] sel_q;
    logic compMode_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] compare_q;
    logic [DEAD_W-1:0] dead_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cap_q;
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] mask_q;
    logic tcPulse_q;
    logic cmpRaw_q;
    logic capPrev_q;
    logic cmpOut_q;
    logic tcOut_q;
    logic [DATA_W-1:0] rdData_q;
    logic cmpTrue;
    logic dbHi;
    logic dbLo;
    // ****************************************
    // register decode
    // ****************************************
    wire wrCtrl = regWr && (regAddr == REG_CTRL);
    wire wrPeriod = regWr && (regAddr == REG_PERIOD);
    wire wrCompare = regWr && (regAddr == REG_COMPARE);
    wire wrStatus = regWr && (regAddr == REG_STATUS);
    wire wrMask = regWr && (regAddr == REG_MASK);
    wire wrDead = regWr && (regAddr == REG_DEADBAND);
    wire runWr = regWrData[CTRL_RUN];
    wire startPulse = wrCtrl && runWr && !runEn_q;
    // ****************************************
    // counting clock and step
    // ****************************************
    wire [NSRC-1:0] srcVec = {tickIn, 1'b1};
    // out of range selections stall the counter instead of reading past the vector
    wire selOk = 32'(sel_q) < NSRC;
    wire tick = selOk && srcVec[sel_q]; // [R02]
    runMode_t mode;
    assign mode = runMode_t'(mode_q);
    wire gateOk = (mode != MODE_GATED) || enableIn; // [R07] [R09]
    wire step = runEn_q && tick && gateOk;
    wire atZero = cnt_q == CNT_ZERO;
    wire tcEvent = step && atZero;
    wire reload = startPulse || resetIn;
    wire oneShotEnd = tcEvent && (mode == MODE_ONESHOT);
    // ****************************************
    // counter
    // ****************************************
    always_comb begin
        cnt_d = cnt_q;
        if (reload) begin
            cnt_d = period_q; // [R04]
        end else if (tcEvent) begin
            cnt_d = period_q; // [R04]
        end else if (step) begin
            cnt_d = cnt_q - CNT_STEP; // [R01]
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= PERIOD_RST;
            tcPulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tcPulse_q <= tcEvent; // [R13]
        end
    end
    // ****************************************
    // control registers
    // ****************************************
    // a start written in the same cycle as the one shot end wins, so no start is lost
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            runEn_q <= 1'b0;
            mode_q <= MODE_FREE;
            rel_q <= REL_LT;
            sel_q <= SEL_RST;
            compMode_q <= 1'b0;
        end else if (wrCtrl) begin
            runEn_q <= runWr;
            mode_q <= regWrData[CTRL_MODE_LO +: 2]; // [R07]
            rel_q <= regWrData[CTRL_REL_LO +: 3]; // [R03]
            sel_q <= regWrData[CTRL_SEL_LO +: SEL_W]; // [R02]
            compMode_q <= regWrData[CTRL_COMP]; // [R06]
        end else if (oneShotEnd) begin
            runEn_q <= 1'b0; // [R08]
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            period_q <= PERIOD_RST;
            compare_q <= COMPARE_RST;
            dead_q <= DEAD_RST;
            mask_q <= EVT_NONE;
        end else begin
            if (wrPeriod) begin
                period_q <= regWrData;
            end
            if (wrCompare) begin
                compare_q <= regWrData;
            end
            if (wrDead) begin
                dead_q <= regWrData[DEAD_W-1:0];
            end
            if (wrMask) begin
                mask_q <= regWrData[EVT_W-1:0]; // [R05]
            end
        end
    end
    // ****************************************
    // compare, capture, events
    // ****************************************
    cmp_unit #(
        .W(CNT_W)
    ) u_cmp (
        .count(cnt_q),
        .compare(compare_q),
        .rel(rel_q),
        .match(cmpTrue)
    );
    wire capEdge = captureIn && !capPrev_q;
    wire cmpRise = cmpTrue && !cmpRaw_q;
    wire [EVT_W-1:0] evt = {capEdge, cmpRise, tcEvent};
    wire [EVT_W-1:0] clrBits = wrStatus ? regWrData[EVT_W-1:0] : EVT_NONE;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cap_q <= CNT_ZERO;
            capPrev_q <= 1'b0;
            cmpRaw_q <= 1'b0;
            status_q <= EVT_NONE;
        end else begin
            capPrev_q <= captureIn;
            cmpRaw_q <= cmpTrue;
            if (capEdge) begin
                cap_q <= cnt_q; // [R10]
            end
            // set beats a write-one clear arriving in the same cycle
            status_q <= (status_q & ~clrBits) | evt; // [R05]
        end
    end
    assign irq = |(status_q & mask_q); // [R05] [R06]
    // ****************************************
    // output stage
    // ****************************************
    deadband_gen #(
        .W(DEAD_W)
    ) u_dead (
        .mclk(mclk),
        .rst_n(rst_n),
        .pwmIn(cmpRaw_q),
        .deadLen(dead_q),
        .hiOut(dbHi),
        .loOut(dbLo)
    );
    // kill acts one cycle late since the pins are registered; the tc pulse is not killed
    wire cmpOut_d = killIn ? 1'b0 : (compMode_q ? dbHi : cmpRaw_q); // [R11] [R12]
    wire tcOut_d = compMode_q ? (!killIn && dbLo) : tcPulse_q; // [R06] [R11] [R13]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmpOut_q <= 1'b0;
            tcOut_q <= 1'b0;
        end else begin
            cmpOut_q <= cmpOut_d;
            tcOut_q <= tcOut_d;
        end
    end
    assign cmpOut = cmpOut_q;
    assign tcOut = tcOut_q;
    // ****************************************
    // read port
    // ****************************************
    wire [DATA_W-1:0] ctrlView = DATA_W'({compMode_q, sel_q, rel_q, mode_q, runEn_q});
    wire [DATA_W-1:0] statView = DATA_W'({runEn_q, 5'h00, status_q});
    wire [DATA_W-1:0] rdMux =
        (regAddr == REG_CTRL) ? ctrlView :
        (regAddr == REG_PERIOD) ? period_q :
        (regAddr == REG_COMPARE) ? compare_q :
        (regAddr == REG_COUNT) ? cnt_q :
        (regAddr == REG_CAPTURE) ? cap_q :
        (regAddr == REG_STATUS) ? statView :
        (regAddr == REG_MASK) ? DATA_W'(mask_q) :
        (regAddr == REG_DEADBAND) ? DATA_W'(dead_q) : DATA_ZERO;
    // reads have no side effect, so polling the count never disturbs it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData_q <= DATA_ZERO;
        end else begin
            rdData_q <= regRd ? rdMux : DATA_ZERO; // [R14]
        end
    end
    assign regRdData = rdData_q;
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_countDown;
        step && !atZero && !reload |=> cnt_q == $past(cnt_q) - CNT_STEP;
    endproperty
    a_countDown: assert property (p_countDown) else $error("count did not decrement"); // [R01]
    property p_reloadTc;
        tcEvent && !reload |=> cnt_q == $past(period_q);
    endproperty
    a_reloadTc: assert property (p_reloadTc) else $error("no reload at zero"); // [R04]
    property p_reloadIn;
        resetIn |=> cnt_q == $past(period_q);
    endproperty
    a_reloadIn: assert property (p_reloadIn) else $error("no reload on reset input"); // [R04]
    property p_tcPulse;
        tcEvent ##1 !tcEvent |-> tcPulse_q ##1 !tcPulse_q;
    endproperty
    a_tcPulse: assert property (p_tcPulse) else $error("tc pulse wrong length"); // [R13]
    property p_oneShot;
        oneShotEnd && !wrCtrl |=> !runEn_q && (cnt_q == $past(period_q));
    endproperty
    a_oneShot: assert property (p_oneShot) else $error("one shot kept running"); // [R08]
    property p_gated;
        runEn_q && mode == MODE_GATED && !enableIn && !reload |=> $stable(cnt_q);
    endproperty
    a_gated: assert property (p_gated) else $error("gated counter moved"); // [R09]
    property p_capture;
        capEdge |=> cap_q == $past(cnt_q);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong"); // [R10]
    property p_kill;
        killIn ##1 killIn |-> !cmpOut_q && !(compMode_q && tcOut_q);
    endproperty
    a_kill: assert property (p_kill) else $error("output active under kill"); // [R11]
    property p_irqTc;
        tcEvent && mask_q[ST_TC] && !wrMask |=> irq && status_q[ST_TC];
    endproperty
    a_irqTc: assert property (p_irqTc) else $error("tc did not raise interrupt"); // [R05]
    property p_eqRel;
        rel_q == REL_EQ && cnt_q == compare_q |=> cmpRaw_q;
    endproperty
    a_eqRel: assert property (p_eqRel) else $error("equal relation missed"); // [R03]
    property p_liveRead;
        regRd && regAddr == REG_COUNT |=> regRdData == $past(cnt_q);
    endproperty
    a_liveRead: assert property (p_liveRead) else $error("live count read wrong"); // [R14]
    property p_srcStall;
        runEn_q && !tick && !reload |=> $stable(cnt_q);
    endproperty
    a_srcStall: assert property (p_srcStall) else $error("count without source tick"); // [R02]
    property p_startLoad;
        startPulse |=> cnt_q == $past(period_q);
    endproperty
    a_startLoad: assert property (p_startLoad) else $error("no reload on start"); // [R04]
    property p_noUp;
        !reload && !tcEvent |=> cnt_q <= $past(cnt_q);
    endproperty
    a_noUp: assert property (p_noUp) else $error("count moved upward"); // [R01]
    property p_freeCount;
        runEn_q && mode == MODE_FREE && tick && !atZero && !reload |=> cnt_q != $past(cnt_q);
    endproperty
    a_freeCount: assert property (p_freeCount) else $error("free run missed a tick"); // [R07]
    property p_stopHold;
        !runEn_q && !wrCtrl && !resetIn |=> $stable(cnt_q);
    endproperty
    a_stopHold: assert property (p_stopHold) else $error("stopped counter moved"); // [R08]
    property p_tcFlag;
        tcEvent |=> status_q[ST_TC];
    endproperty
    a_tcFlag: assert property (p_tcFlag) else $error("tc flag not set"); // [R05]
    property p_cmpFlag;
        cmpRise |=> status_q[ST_CMP];
    endproperty
    a_cmpFlag: assert property (p_cmpFlag) else $error("compare flag not set"); // [R05]
    property p_capFlag;
        capEdge |=> status_q[ST_CAP];
    endproperty
    a_capFlag: assert property (p_capFlag) else $error("capture flag not set"); // [R05]
    property p_sticky;
        status_q[ST_TC] && !(wrStatus && regWrData[ST_TC]) |=> status_q[ST_TC];
    endproperty
    a_sticky: assert property (p_sticky) else $error("tc flag dropped by itself"); // [R05]
    property p_w1c;
        wrStatus && regWrData[ST_TC] && !tcEvent |=> !status_q[ST_TC];
    endproperty
    a_w1c: assert property (p_w1c) else $error("tc flag not cleared"); // [R05]
    property p_rdIdle;
        !regRd |=> regRdData == DATA_ZERO;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle"); // [R14]
    property p_killCmp;
        killIn |=> !cmpOut_q;
    endproperty
    a_killCmp: assert property (p_killCmp) else $error("compare output under kill"); // [R11]
    property p_killTc;
        killIn && compMode_q |=> !tcOut_q;
    endproperty
    a_killTc: assert property (p_killTc) else $error("low side active under kill"); // [R11]
    property p_pairApart;
        compMode_q && $past(compMode_q) |-> !(cmpOut_q && tcOut_q);
    endproperty
    a_pairApart: assert property (p_pairApart) else $error("pair pins both active"); // [R12]
    c_tc: cover property (tcEvent);
    c_capture: cover property (capEdge && runEn_q);
    c_oneShotEnd: cover property (oneShotEnd);
    c_killComp: cover property (killIn && compMode_q && cmpRaw_q);
    c_compPair: cover property (compMode_q && dbHi);
endmodule
`default_nettype wire

// file: rtl/timer_pkg.sv
// package: register map, field layout, reset values and modes of the timer block
package timer_pkg;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int DEAD_W = 8;
    localparam int SEL_W = 2;
    localparam int EVT_W = 3;
    // ****************************************
    // register offsets (word index)
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h1;
    localparam logic [ADDR_W-1:0] REG_COMPARE = 4'h2;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CAPTURE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h6;
    localparam logic [ADDR_W-1:0] REG_DEADBAND = 4'h7;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_REL_LO = 3;
    localparam int CTRL_SEL_LO = 6;
    localparam int CTRL_COMP = 8;
    localparam int ST_TC = 0;
    localparam int ST_CMP = 1;
    localparam int ST_CAP = 2;
    localparam int ST_RUNNING = 8;
    // ****************************************
    // reset values and constants
    // ****************************************
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] COMPARE_RST = 16'h8000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
    localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
    localparam logic [DEAD_W-1:0] DEAD_STEP = 8'h01;
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
    localparam logic [EVT_W-1:0] EVT_NONE = 3'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    typedef enum logic [1:0] {
        MODE_FREE = 2'b00,
        MODE_ONESHOT = 2'b01,
        MODE_GATED = 2'b10
    } runMode_t;
    typedef enum logic [2:0] {
        REL_LT = 3'b000,
        REL_LTE = 3'b001,
        REL_EQ = 3'b010,
        REL_GTE = 3'b011,
        REL_GT = 3'b100
    } cmpRel_t;
endpackage

// file: testbench/fabric_model.sv
// routed-logic model: count-source ticks and control lines for the timer
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enReq,
    input wire logic rstReq,
    input wire logic capReq,
    input wire logic killReq,
    output logic [2:0] tickIn,
    output logic enableIn,
    output logic resetIn,
    output logic captureIn,
    output logic killIn
);
    logic [2:0] divCnt_q;
    // ********
    // tick sources
    // ********
    // fixed rates mclk/4, mclk/2, mclk/8 keep expected spans simple
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            divCnt_q <= 3'h0;
            tickIn <= 3'h0;
        end else begin
            divCnt_q <= divCnt_q + 3'h1;
            tickIn <= {divCnt_q == 3'h7, divCnt_q[0], divCnt_q[1:0] == 2'h3};
        end
    end
    // registered like any routed signal, so changes land just after an edge
    always_ff @(posedge mclk) begin
        enableIn <= enReq;
        resetIn <= rstReq;
        captureIn <= capReq;
        killIn <= killReq;
    end
endmodule
`default_nettype wire

// file: testbench/timer_counter_pwm16_tb.sv
// self-checking bench for the 16-bit timer, counter and pwm unit
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm16_tb import timer_pkg::*;;
    logic mclk, rst_n, regWr, regRd, enableIn, resetIn, captureIn, killIn;
    logic cmpOut, tcOut, irq, enReq, rstReq, capReq, killReq;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, d, e;
    logic [2:0] tickIn;
    int miscompares, samplesChecked;
    timer_counter_pwm16 #(.NSRC(4)) dut_u (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .tickIn(tickIn), .enableIn(enableIn), .resetIn(resetIn), .captureIn(captureIn),
        .killIn(killIn), .cmpOut(cmpOut), .tcOut(tcOut), .irq(irq));
    fabric_model fab_u (.mclk(mclk), .rst_n(rst_n), .enReq(enReq), .rstReq(rstReq),
        .capReq(capReq), .killReq(killReq), .tickIn(tickIn), .enableIn(enableIn),
        .resetIn(resetIn), .captureIn(captureIn), .killIn(killIn));
    // ********
    // bus and check tasks
    // ********
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [ADDR_W-1:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        chk({15'h0, seen}, {15'h0, exp});
    endtask
    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // cycles from one terminal-count pulse to the next, bounded
    task automatic tcGap(output int n);
        n = 0;
        while (tcOut !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (tcOut !== 1'b1 && n < 300);
    endtask
    function automatic logic [DATA_W-1:0] ctl(input logic [1:0] m, input logic [2:0] r,
        input logic [1:0] s, input logic c);
        ctl = 16'h0001 | (16'(m) << CTRL_MODE_LO) | (16'(r) << CTRL_REL_LO)
            | (16'(s) << CTRL_SEL_LO) | (16'(c) << CTRL_COMP);
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // budget is roughly fifty times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        stop_test;
    end
    // ********
    // tests
    // ********
    initial begin
        int n;
        int divs[4];
        logic [4:0] relExp;
        divs = '{1, 4, 2, 8};
        relExp = 5'b01110;
        {rst_n, regWr, regRd, enReq, rstReq, capReq, killReq} = 7'h00;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        miscompares = 0;
        samplesChecked = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdChk(REG_PERIOD, PERIOD_RST);
        cyc(0);
        chk(regRdData, DATA_ZERO);
        rdChk(REG_COMPARE, COMPARE_RST);
        rdChk(REG_COUNT, PERIOD_RST);
        rdChk(REG_STATUS, DATA_ZERO);
        rdChk(REG_MASK, DATA_ZERO);
        rdChk(REG_DEADBAND, DATA_ZERO);
        wr(4'h9, 16'h1234);
        rdChk(4'h9, DATA_ZERO);
        wr(REG_COUNT, 16'h0005);
        rdChk(REG_COUNT, PERIOD_RST);
        $display("test reset_values finished");
        wr(REG_PERIOD, 16'h0002);
        for (int s = 0; s < 4; s++) begin
            wr(REG_CTRL, 16'h0000);
            wr(REG_CTRL, ctl(MODE_FREE, REL_LT, 2'(s), 1'b0));
            tcGap(n);
            chk(16'(n), 16'(3 * divs[s]));
        end
        chk1(irq, 1'b0);
        wr(REG_MASK, 16'h0001);
        chk1(irq, 1'b1);
        wr(REG_CTRL, 16'h0000);
        rd(REG_STATUS);
        chk1(d[ST_TC], 1'b1);
        wr(REG_STATUS, 16'h0007);
        rd(REG_STATUS);
        chk1(d[ST_TC], 1'b0);
        chk1(irq, 1'b0);
        $display("test free_run_sources finished");
        wr(REG_PERIOD, 16'h0003);
        wr(REG_CTRL, ctl(MODE_ONESHOT, REL_LT, 2'h0, 1'b0));
        n = 0;
        repeat (40) begin
            cyc(1);
            if (tcOut === 1'b1) n++;
        end
        chk(16'(n), 16'h0001);
        rd(REG_STATUS);
        chk1(d[ST_RUNNING], 1'b0);
        $display("test one_shot finished");
        wr(REG_CTRL, 16'h0000);
        wr(REG_PERIOD, 16'h0123);
        wr(REG_CTRL, ctl(MODE_GATED, REL_LT, 2'h0, 1'b0));
        cyc(4);
        rdChk(REG_COUNT, 16'h0123);
        enReq <= 1'b1;
        cyc(10);
        enReq <= 1'b0;
        cyc(4);
        rd(REG_COUNT);
        e = d;
        chk(e, 16'h0119);
        rdChk(REG_COUNT, e);
        capReq <= 1'b1;
        cyc(3);
        capReq <= 1'b0;
        cyc(3);
        rdChk(REG_CAPTURE, e);
        rd(REG_STATUS);
        chk1(d[ST_CAP], 1'b1);
        wr(REG_STATUS, 16'h0003);
        wr(REG_MASK, 16'h0004);
        chk1(irq, 1'b1);
        wr(REG_STATUS, 16'h0004);
        chk1(irq, 1'b0);
        rstReq <= 1'b1;
        cyc(1);
        rstReq <= 1'b0;
        cyc(4);
        rdChk(REG_COUNT, 16'h0123);
        enReq <= 1'b1;
        rd(REG_COUNT);
        e = d;
        rd(REG_COUNT);
        chk1(d < e, 1'b1);
        enReq <= 1'b0;
        $display("test gated_capture finished");
        rstReq <= 1'b1;
        cyc(1);
        rstReq <= 1'b0;
        wr(REG_COMPARE, 16'h0123);
        for (int r = 0; r < 5; r++) begin
            wr(REG_CTRL, ctl(MODE_GATED, 3'(r), 2'h0, 1'b0));
            cyc(4);
            chk1(cmpOut, relExp[r]);
        end
        wr(REG_CTRL, ctl(MODE_GATED, REL_EQ, 2'h0, 1'b0));
        killReq <= 1'b1;
        cyc(4);
        chk1(cmpOut, 1'b0);
        killReq <= 1'b0;
        cyc(4);
        chk1(cmpOut, 1'b1);
        wr(REG_MASK, 16'h0002);
        chk1(irq, 1'b1);
        rd(REG_STATUS);
        chk1(d[ST_CMP], 1'b1);
        $display("test compare_kill finished");
        wr(REG_DEADBAND, 16'h0004);
        wr(REG_CTRL, ctl(MODE_GATED, REL_GT, 2'h0, 1'b1));
        cyc(12);
        chk1(tcOut, 1'b1);
        wr(REG_CTRL, ctl(MODE_GATED, REL_EQ, 2'h0, 1'b1));
        n = 0;
        for (int m = 0; m < 60 && cmpOut !== 1'b1; m++) begin
            cyc(1);
            if (cmpOut === 1'b0 && tcOut === 1'b0) n++;
        end
        chk(16'(n), 16'h0005);
        chk1(tcOut, 1'b0);
        killReq <= 1'b1;
        cyc(3);
        chk1(cmpOut, 1'b0);
        chk1(tcOut, 1'b0);
        $display("test deadband finished");
        stop_test;
    end
endmodule
`default_nettype wire
